// File: design/iso_packet_formatter.sv
// link end: queued packets to bus packets, bus packets to host quadlets
// assumes the bus side delivers whole quadlets and a grant after each request
`timescale 1ns/10ps
module iso_packet_formatter (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   iso_link_if.dev                lnk,
   input  wire logic              cycle_start,
   output logic                   bus_req,
   input  wire logic              bus_grant,
   output logic                   bus_tx_valid,
   input  wire logic              bus_tx_ready,
   output iso_fmt_pkg::quad_t     bus_tx_data,
   output logic                   bus_tx_last,
   output iso_fmt_pkg::spd_t      bus_tx_spd,
   input  wire logic              bus_rx_valid,
   output logic                   bus_rx_ready,
   input  wire iso_fmt_pkg::quad_t bus_rx_data,
   input  wire logic              bus_rx_last,
   input  wire iso_fmt_pkg::spd_t bus_rx_spd,
   input  wire logic              bus_rx_crc_bad,
   output logic                   tx_dropped
);
   import iso_fmt_pkg::*;

   typedef enum logic [2:0] {T_IDLE, T_REQ, T_HDR, T_PAY, T_DROP} tx_state_e;
   typedef enum logic [1:0] {R_HDR, R_PAY, R_STAT} rx_state_e;

   tx_state_e   tx_st_ff;
   logic        armed_ff;
   logic        bus_req_ff;
   logic        tx_ready_ff;
   logic        btx_valid_ff;
   quad_t       btx_data_ff;
   logic        btx_last_ff;
   spd_t        btx_spd_ff;
   logic [14:0] tx_left_ff;
   logic        dropped_ff;

   rx_state_e   rx_st_ff;
   logic        brx_ready_ff;
   logic        rx_valid_ff;
   quad_t       rx_data_ff;
   logic [14:0] rx_left_ff;
   logic [13:0] blk_cnt_ff;
   logic [1:0]  rx_len_lo_ff;
   spd_t        rx_spd_ff;
   logic        done_ff;
   logic [3:0]  res_ff;

   logic        tx_take;
   logic        tx_slot_free;
   logic        rx_load;
   logic        rx_slot_free;
   logic [15:0] tx_len;
   logic [15:0] rx_len;
   logic [13:0] blk_inc;

   assign tx_take      = lnk.tx_valid & tx_ready_ff;
   assign tx_slot_free = ~btx_valid_ff | bus_tx_ready;
   assign rx_load      = bus_rx_valid & brx_ready_ff;
   assign rx_slot_free = ~rx_valid_ff | lnk.rx_ready;
   assign tx_len       = lnk.tx_data[LEN_MSB:LEN_LSB];
   assign rx_len       = bus_rx_data[LEN_MSB:LEN_LSB];
   assign blk_inc      = blk_cnt_ff + 14'h0001;

   assign bus_req      = bus_req_ff;
   assign bus_tx_valid = btx_valid_ff;
   assign bus_tx_data  = btx_data_ff;
   assign bus_tx_last  = btx_last_ff;
   assign bus_tx_spd   = btx_spd_ff;
   assign bus_rx_ready = brx_ready_ff;
   assign tx_dropped   = dropped_ff;
   assign lnk.tx_ready = tx_ready_ff;
   assign lnk.rx_valid = rx_valid_ff;
   assign lnk.rx_data  = rx_data_ff;

   // cycle_start arms sending until the queue runs dry
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_ff <= 1'b0;
      end else if (cycle_start) begin
         armed_ff <= 1'b1;
      end else if (tx_st_ff == T_IDLE && !lnk.tx_valid) begin
         armed_ff <= 1'b0;
      end
   end

   // tx sequencing; packets leave in queue order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_st_ff   <= T_IDLE;
         bus_req_ff <= 1'b0;
         tx_left_ff <= 15'h0000;
         dropped_ff <= 1'b0;
      end else begin
         dropped_ff <= 1'b0;
         case (tx_st_ff)
            T_IDLE: begin
               if ((armed_ff || cycle_start) && lnk.tx_valid) begin
                  bus_req_ff <= 1'b1;
                  tx_st_ff   <= T_REQ;
               end
            end
            T_REQ: begin
               if (bus_grant) begin
                  bus_req_ff <= 1'b0;
                  tx_st_ff   <= T_HDR;
               end
            end
            T_HDR: begin
               if (tx_take) begin
                  tx_left_ff <= quads_of(tx_len);
                  if (lnk.tx_data[SPD_MSB:SPD_LSB] == SPD_UNDEF) begin
                     dropped_ff <= 1'b1;
                     tx_st_ff   <= (tx_len == 16'h0000) ? T_IDLE : T_DROP;
                  end else begin
                     tx_st_ff <= (tx_len == 16'h0000) ? T_IDLE : T_PAY;
                  end
               end
            end
            T_PAY, T_DROP: begin
               if (tx_take) begin
                  tx_left_ff <= tx_left_ff - 15'h0001;
                  if (tx_left_ff == 15'h0001) begin
                     tx_st_ff <= T_IDLE;
                  end
               end
            end
            default: begin
               tx_st_ff <= T_IDLE;
            end
         endcase
      end
   end

   // one-cycle ready per quadlet; the host holds valid, so it always lands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_ready_ff <= 1'b0;
      end else begin
         tx_ready_ff <= ~tx_take & ~tx_ready_ff & lnk.tx_valid &
                        (((tx_st_ff == T_HDR || tx_st_ff == T_PAY) & tx_slot_free) |
                         (tx_st_ff == T_DROP));
      end
   end

   // bus output register; header rebuilt with the iso tcode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         btx_valid_ff <= 1'b0;
         btx_data_ff  <= 32'h00000000;
         btx_last_ff  <= 1'b0;
         btx_spd_ff   <= SPD_S100;
      end else if (tx_take && tx_st_ff == T_HDR &&
                   lnk.tx_data[SPD_MSB:SPD_LSB] != SPD_UNDEF) begin
         btx_valid_ff <= 1'b1;
         btx_data_ff  <= {tx_len,
                          lnk.tx_data[TAG_MSB:TAG_LSB],
                          lnk.tx_data[CHAN_MSB:CHAN_LSB],
                          TCODE_ISO,
                          lnk.tx_data[SY_MSB:SY_LSB]};
         btx_last_ff  <= (tx_len == 16'h0000);
         btx_spd_ff   <= lnk.tx_data[SPD_MSB:SPD_LSB];
      end else if (tx_take && tx_st_ff == T_PAY) begin
         btx_valid_ff <= 1'b1;
         btx_data_ff  <= lnk.tx_data;
         btx_last_ff  <= (tx_left_ff == 15'h0001);
      end else if (bus_tx_ready) begin
         btx_valid_ff <= 1'b0;
      end
   end

   // receive: header, payload bounded by length, status per block
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_st_ff     <= R_HDR;
         rx_valid_ff  <= 1'b0;
         rx_data_ff   <= 32'h00000000;
         rx_left_ff   <= 15'h0000;
         blk_cnt_ff   <= 14'h0000;
         rx_len_lo_ff <= 2'h0;
         rx_spd_ff    <= SPD_S100;
         done_ff      <= 1'b0;
         res_ff       <= RES_COMPLETE;
      end else begin
         if (lnk.rx_ready) begin
            rx_valid_ff <= 1'b0;
         end
         case (rx_st_ff)
            R_HDR: begin
               if (rx_load) begin
                  rx_valid_ff  <= 1'b1;
                  rx_data_ff   <= {bus_rx_data[31:TC_MSB+1], TCODE_ISO,
                                   bus_rx_data[SY_MSB:SY_LSB]};
                  rx_left_ff   <= quads_of(rx_len);
                  rx_len_lo_ff <= rx_len[1:0];
                  rx_spd_ff    <= bus_rx_spd;
                  blk_cnt_ff   <= 14'h0000;
                  if (bus_rx_last) begin
                     done_ff  <= 1'b1;
                     res_ff   <= bus_rx_crc_bad ? crc_error_result :
                                 (rx_len != 16'h0000) ? data_error_result : RES_COMPLETE;
                     rx_st_ff <= R_STAT;
                  end else begin
                     rx_st_ff <= R_PAY;
                  end
               end
            end
            R_PAY: begin
               if (rx_load) begin
                  if (rx_left_ff != 15'h0000) begin
                     rx_valid_ff <= 1'b1;
                     rx_data_ff  <= (rx_left_ff == 15'h0001) ?
                                    tail_mask(bus_rx_data, rx_len_lo_ff) : bus_rx_data;
                     rx_left_ff  <= rx_left_ff - 15'h0001;
                     blk_cnt_ff  <= blk_inc;
                  end
                  if (bus_rx_last) begin
                     done_ff  <= 1'b1;
                     res_ff   <= bus_rx_crc_bad ? crc_error_result :
                                 (rx_left_ff > 15'h0001) ? data_error_result : RES_COMPLETE;
                     rx_st_ff <= R_STAT;
                  end else if (rx_left_ff != 15'h0000 && blk_inc == RX_BLOCK_QUADS) begin
                     done_ff  <= 1'b0;
                     res_ff   <= RES_COMPLETE;
                     rx_st_ff <= R_STAT;
                  end
               end
            end
            R_STAT: begin
               if (rx_slot_free) begin
                  rx_valid_ff <= 1'b1;
                  rx_data_ff  <= (quad_t'(blk_cnt_ff) << ST_CNT_LSB) |
                                 (quad_t'(rx_spd_ff) << ST_SPD_LSB) |
                                 (quad_t'(done_ff) << ST_DONE_BIT) |
                                 (quad_t'(res_ff) << ST_RES_LSB);
                  blk_cnt_ff  <= 14'h0000;
                  rx_st_ff    <= done_ff ? R_HDR : R_PAY;
               end
            end
            default: begin
               rx_st_ff <= R_HDR;
            end
         endcase
      end
   end

   // take a bus quadlet only when the rx slot is free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brx_ready_ff <= 1'b0;
      end else begin
         brx_ready_ff <= ~rx_load & (rx_st_ff != R_STAT) & rx_slot_free;
      end
   end
endmodule

// File: pkg/iso_fmt_pkg.sv
// constants and helpers shared by both ends of the formatter
// assumes one clock; byte 0 of a quadlet is bits 31:24
// Functional notes
// - request bus right after a cycle-start when a packet is queued
// - host queues packets in sending order
// - header length counts bytes, not quadlets
// - tag 00 formatted; 01..11 reserved
// - speed 00/01/10 = 100/200/400; 11 undefined
// - header channel selects sending channel
// - sync bits pass unchanged both ways
// - host puts byte0 first, zero pads tail
// - receive byte length bounds payload
// - complete flag 1 last block, else 0
// - status reports payload quadlets written
// - result codes: complete, data error, crc
// - stored receive header tcode is A
// - receive header keeps channel, tag, length; speed goes to status
// - receive byte0 first, zero-fill final quadlet
package iso_fmt_pkg;
   typedef logic [31:0] quad_t;
   typedef logic [1:0]  spd_t;

   // header quadlet layout, host and bus side
   localparam int LEN_MSB  = 31;
   localparam int LEN_LSB  = 16;
   localparam int TAG_MSB  = 15;
   localparam int TAG_LSB  = 14;
   localparam int CHAN_MSB = 13;
   localparam int CHAN_LSB = 8;
   localparam int SPD_MSB  = 7;   // host transmit header only
   localparam int SPD_LSB  = 6;
   localparam int TC_MSB   = 7;   // bus and receive header
   localparam int TC_LSB   = 4;
   localparam int SY_MSB   = 3;
   localparam int SY_LSB   = 0;

   localparam logic [3:0] TCODE_ISO     = 4'hA;
   localparam logic [1:0] TAG_FORMATTED = 2'h0;
   localparam spd_t       SPD_S100      = 2'h0;
   localparam spd_t       SPD_S200      = 2'h1;
   localparam spd_t       SPD_S400      = 2'h2;
   localparam spd_t       SPD_UNDEF     = 2'h3;

   // status quadlet layout
   localparam int ST_CNT_LSB  = 18;
   localparam int ST_SPD_LSB  = 16;
   localparam int ST_DONE_BIT = 11;
   localparam int ST_RES_LSB  = 0;

   localparam logic [3:0]  RES_COMPLETE     = 4'h1;
   localparam logic [3:0]  data_error_result = 4'hD;
   localparam logic [3:0]  crc_error_result  = 4'hE;
   localparam logic [13:0] RX_BLOCK_QUADS   = 14'h0010;

   // register map, byte addresses
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] A_TX_WORD    = 8'h00;
   localparam logic [7:0] A_RX_WORD    = 8'h04;
   localparam logic [7:0] A_STATUS     = 8'h08;
   localparam logic [7:0] A_INT_STATUS = 8'h0C;
   localparam logic [7:0] A_INT_CLEAR  = 8'h10;
   localparam logic [7:0] A_INT_ENABLE = 8'h14;
   localparam int         INT_RX_BIT   = 0;
   localparam int         INT_TX_BIT   = 1;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   function automatic logic [14:0] quads_of(input logic [15:0] len);
      logic [16:0] s;
      s = {1'b0, len} + 17'h00003;
      return s[16:2];
   endfunction

   // keeps the first n bytes; 0 keeps all four
   function automatic quad_t tail_mask(input quad_t d, input logic [1:0] n);
      quad_t m;
      m = 32'hFFFFFFFF;
      case (n)
         2'h1:    m = 32'hFF000000;
         2'h2:    m = 32'hFFFF0000;
         2'h3:    m = 32'hFFFFFF00;
         default: m = 32'hFFFFFFFF;
      endcase
      return d & m;
   endfunction
endpackage

// File: pkg/iso_link_if.sv
// quadlet streams between formatter and controller
// assumes one shared clock; a word moves on valid and ready
`timescale 1ns/10ps
interface iso_link_if;
   logic              tx_valid;
   logic              tx_ready;
   iso_fmt_pkg::quad_t tx_data;
   logic              rx_valid;
   logic              rx_ready;
   iso_fmt_pkg::quad_t rx_data;

   modport dev (input tx_valid, input tx_data, output tx_ready,
                output rx_valid, output rx_data, input rx_ready);
   modport ctl (output tx_valid, output tx_data, input tx_ready,
                input rx_valid, input rx_data, output rx_ready);
endinterface

// File: design/iso_host_ctl.sv
// controller end: axi4-lite registers that push and pop link quadlets
// assumes software writes whole, padded packets in order
`timescale 1ns/10ps
module iso_host_ctl (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   iso_link_if.ctl                lnk,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire iso_fmt_pkg::quad_t s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [7:0]        s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output iso_fmt_pkg::quad_t     s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   irq
);
   import iso_fmt_pkg::*;

   logic       awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, irq_ff;
   logic       aw_hold_ff, w_hold_ff;
   logic [7:0] awaddr_ff;
   quad_t      wdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   quad_t      rdata_ff;
   logic       tx_valid_ff, rx_ready_ff, rx_avail_ff;
   quad_t      tx_data_ff, rx_word_ff;
   logic [1:0] int_st_ff, int_en_ff;

   logic       wr_go, rd_go, aw_take, w_take, rx_take;
   logic       pop;
   logic [1:0] clr, set;

   assign aw_take = s_axi_awvalid & awready_ff;
   assign w_take  = s_axi_wvalid & wready_ff;
   // a tx write waits while the last quadlet is offered
   assign wr_go   = aw_hold_ff & w_hold_ff & ~bvalid_ff &
                    ~(awaddr_ff == A_TX_WORD && tx_valid_ff);
   assign rd_go   = s_axi_arvalid & arready_ff;
   assign rx_take = lnk.rx_valid & rx_ready_ff;
   assign pop     = rd_go & (s_axi_araddr == A_RX_WORD) & rx_avail_ff;
   assign clr     = (wr_go && awaddr_ff == A_INT_CLEAR) ? wdata_ff[1:0] : 2'h0;
   assign set     = {lnk.tx_valid & lnk.tx_ready, rx_take};

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign irq           = irq_ff;
   assign lnk.tx_valid  = tx_valid_ff;
   assign lnk.tx_data   = tx_data_ff;
   assign lnk.rx_ready  = rx_ready_ff;

   // address and data caught in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 32'h00000000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
      end else begin
         awready_ff <= s_axi_awvalid & ~aw_hold_ff & ~awready_ff;
         wready_ff  <= s_axi_wvalid & ~w_hold_ff & ~wready_ff;
         if (aw_take) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (w_take) begin
            w_hold_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= (awaddr_ff == A_TX_WORD || awaddr_ff == A_INT_CLEAR ||
                           awaddr_ff == A_INT_ENABLE) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // tx quadlets leave in write order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_valid_ff <= 1'b0;
         tx_data_ff  <= 32'h00000000;
      end else if (wr_go && awaddr_ff == A_TX_WORD) begin
         tx_valid_ff <= 1'b1;
         tx_data_ff  <= wdata_ff;
      end else if (lnk.tx_ready) begin
         tx_valid_ff <= 1'b0;
      end
   end

   // one rx quadlet held until read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_ready_ff <= 1'b0;
         rx_avail_ff <= 1'b0;
         rx_word_ff  <= 32'h00000000;
      end else begin
         rx_ready_ff <= lnk.rx_valid & ~rx_avail_ff & ~rx_ready_ff;
         if (rx_take) begin
            rx_avail_ff <= 1'b1;
            rx_word_ff  <= lnk.rx_data;
         end else if (pop) begin
            rx_avail_ff <= 1'b0;
         end
      end
   end

   // reads answer one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h00000000;
         rresp_ff   <= RESP_OKAY;
      end else begin
         arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
         if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= RESP_OKAY;
            case (s_axi_araddr)
               A_RX_WORD:    rdata_ff <= rx_avail_ff ? rx_word_ff : 32'h00000000;
               A_STATUS:     rdata_ff <= {30'h00000000, rx_avail_ff, tx_valid_ff};
               A_INT_STATUS: rdata_ff <= {30'h00000000, int_st_ff};
               A_INT_ENABLE: rdata_ff <= {30'h00000000, int_en_ff};
               A_TX_WORD, A_INT_CLEAR: rdata_ff <= 32'h00000000;
               default: begin
                  rdata_ff <= 32'h00000000;
                  rresp_ff <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // sticky events; a new event beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_st_ff <= 2'h0;
         int_en_ff <= 2'h0;
         irq_ff    <= 1'b0;
      end else begin
         int_st_ff <= (int_st_ff & ~clr) | set;
         if (wr_go && awaddr_ff == A_INT_ENABLE && wstrb_ff[0]) begin
            int_en_ff <= wdata_ff[1:0];
         end
         irq_ff <= |(int_st_ff & int_en_ff);
      end
   end
endmodule

// File: bench/iso_packet_formatter_checker.sv
// link and bus-side timing checks
// assumes one clock, instanced by the bench
`timescale 1ns/10ps
module iso_packet_formatter_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic        rx_valid,
   input wire logic        rx_ready,
   input wire logic [31:0] rx_data,
   input wire logic        cycle_start,
   input wire logic        bus_req,
   input wire logic        bus_grant,
   input wire logic        bus_tx_valid,
   input wire logic        bus_tx_ready,
   input wire logic [31:0] bus_tx_data,
   input wire logic [1:0]  bus_tx_spd,
   input wire logic        bus_rx_valid,
   input wire logic        bus_rx_ready,
   input wire logic        tx_dropped
);
   import iso_fmt_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rx_take;
      bus_rx_valid && bus_rx_ready;
   endsequence
   sequence s_tx_stall;
      bus_tx_valid && !bus_tx_ready;
   endsequence
   chk_tx_rdy_pulse: assert property (tx_ready |=> !tx_ready)
      else $error("tx_ready too long");
   chk_rdy_has_valid: assert property (tx_ready |-> tx_valid)
      else $error("ready without valid");
   chk_req_on_start: assert property (cycle_start && tx_valid && !bus_req && !bus_tx_valid |-> ##[1:2] bus_req)
      else $error("no bus_req after start");
   chk_grant_drops: assert property (bus_req && bus_grant |=> !bus_req)
      else $error("bus_req kept after grant");
   chk_bus_hold: assert property (s_tx_stall |=> bus_tx_valid && $stable(bus_tx_data))
      else $error("bus quadlet unstable");
   chk_no_undef_spd: assert property (bus_tx_valid |-> bus_tx_spd != SPD_UNDEF)
      else $error("undefined speed sent");
   chk_drop_pulse: assert property (tx_dropped |=> !tx_dropped)
      else $error("tx_dropped too long");
   chk_rx_answer: assert property (s_rx_take |=> rx_valid)
      else $error("rx quadlet lost");
   chk_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("rx quadlet unstable");
endmodule

// File: bench/iso_packet_formatter_tb.sv
// bench: axi4-lite software side, bus side driven directly
// assumes grant follows request; bus tx stalls every other cycle
`timescale 1ns/10ps
module iso_packet_formatter_tb;
   import iso_fmt_pkg::*;
   logic        aclk, aresetn, cycle_start, bus_grant, bus_tx_ready, bus_rx_valid, bus_rx_last, bus_rx_crc_bad;
   logic        bus_req, bus_tx_valid, bus_tx_last, bus_rx_ready, tx_dropped, irq, s_axi_awvalid, s_axi_awready;
   logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   quad_t       bus_tx_data, bus_rx_data, s_axi_wdata, s_axi_rdata, d;
   spd_t        bus_tx_spd, bus_rx_spd;
   logic [34:0] txq[$];
   int          error_cnt, total_checks, drops;
   iso_link_if lnk();
   iso_packet_formatter iso_packet_formatter_i (.aclk, .aresetn, .lnk(lnk), .cycle_start, .bus_req, .bus_grant,
      .bus_tx_valid, .bus_tx_ready, .bus_tx_data, .bus_tx_last, .bus_tx_spd, .bus_rx_valid, .bus_rx_ready,
      .bus_rx_data, .bus_rx_last, .bus_rx_spd, .bus_rx_crc_bad, .tx_dropped);
   iso_host_ctl iso_host_ctl_i (.aclk, .aresetn, .lnk(lnk), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
   iso_packet_formatter_checker chk_i (.aclk, .aresetn, .tx_valid(lnk.tx_valid), .tx_ready(lnk.tx_ready),
      .rx_valid(lnk.rx_valid), .rx_ready(lnk.rx_ready), .rx_data(lnk.rx_data), .cycle_start, .bus_req, .bus_grant,
      .bus_tx_valid, .bus_tx_ready, .bus_tx_data, .bus_tx_spd, .bus_rx_valid, .bus_rx_ready, .tx_dropped);
   initial begin
      aclk = 0;
      forever #2.5 aclk = ~aclk;
   end
   // samples taken before the edge's updates land
   always @(posedge aclk) begin
      bus_grant <= bus_req;
      bus_tx_ready <= !bus_tx_ready;
      if (bus_tx_valid && bus_tx_ready) txq.push_back({bus_tx_last, bus_tx_spd, bus_tx_data});
      if (tx_dropped) drops++;
   end
   task automatic chk(input string n, input quad_t e, input quad_t g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input quad_t v, input logic [1:0] er);
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, v};
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic rd(input logic [7:0] a, output quad_t v, input logic [1:0] er);
      @(posedge aclk);
      {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      v = s_axi_rdata;
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask
   function automatic quad_t pay(input int i, input logic [15:0] len);
      quad_t p;
      p = 32'hA0B1C2D3 + i * 32'h01010101;
      if (len - 4 * i < 4) p = p & ~(32'hFFFFFFFF >> (8 * (len - 4 * i)));
      return p;
   endfunction
   task automatic send(input logic [15:0] len, input spd_t spd);
      wr(A_TX_WORD, {len, 2'h0, 6'h05, spd, 2'h0, 4'h9}, RESP_OKAY);
      cycle_start <= 1;
      @(posedge aclk);
      cycle_start <= 0;
      for (int i = 0; i < (len + 3) / 4; i++) wr(A_TX_WORD, pay(i, len), RESP_OKAY);
   endtask
   task automatic tx_expect(input logic [15:0] len, input spd_t spd);
      logic [34:0] e;
      while (txq.size() < (len + 3) / 4 + 1) @(posedge aclk);
      e = txq.pop_front();
      chk("tx hdr", {len, 2'h0, 6'h05, TCODE_ISO, 4'h9}, e[31:0]);
      chk("tx spd", 32'(spd), 32'(e[33:32]));
      for (int i = 0; i < (len + 3) / 4; i++) begin
         e = txq.pop_front();
         chk("tx pay", pay(i, len), e[31:0]);
      end
      chk("tx last", 32'h1, 32'(e[34]));
   endtask
   task automatic rxq(input quad_t v, input logic last);
      @(posedge aclk);
      {bus_rx_valid, bus_rx_last, bus_rx_data} <= {1'b1, last, v};
      do @(posedge aclk); while (!bus_rx_ready);
      {bus_rx_valid, bus_rx_data} <= {1'b0, ~v};
   endtask
   task automatic pop(output quad_t v);
      quad_t s;
      s = 0;
      while (!s[1]) rd(A_STATUS, s, RESP_OKAY);
      rd(A_RX_WORD, v, RESP_OKAY);
   endtask
   task automatic rx_expect(input int c);
      quad_t v, st;
      st = {14'(2 - (c == 2)), SPD_S400, 4'h0, 1'b1, 11'h0};
      st[3:0] = c == 0 ? RES_COMPLETE : c == 1 ? crc_error_result : data_error_result;
      pop(v);
      chk("rx hdr", {16'h0006, 2'h0, 6'h07, TCODE_ISO, 4'h3}, v);
      pop(v);
      chk("rx pay", 32'h11223344, v);
      if (c != 2) begin
         pop(v);
         chk("rx tail", 32'h55660000, v);
      end
      pop(v);
      chk("rx status", st, v);
   endtask
   task automatic results();
      if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      results();
   end
   initial begin
      {aresetn, cycle_start, bus_tx_ready, bus_rx_valid, bus_rx_last, bus_rx_crc_bad, bus_rx_data} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, s_axi_wstrb, bus_rx_spd} = {32'h0, 4'hF, SPD_S400};
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      rd(8'h3C, d, RESP_SLVERR);
      chk("unmapped", 32'h0, d);
      wr(8'h40, 32'h1, RESP_SLVERR);
      send(16'h0004, SPD_UNDEF);
      while (drops == 0) @(posedge aclk);
      for (int s = 0; s < 3; s++) begin
         send(16'(3 * s), spd_t'(s));
         tx_expect(16'(3 * s), spd_t'(s));
      end
      chk("irq masked", 32'h0, 32'(irq));
      rd(A_INT_STATUS, d, RESP_OKAY);
      chk("int status", 32'h2, d);
      wr(A_INT_ENABLE, 32'h2, RESP_OKAY);
      rd(A_INT_ENABLE, d, RESP_OKAY);
      chk("int enable", 32'h2, d);
      chk("irq raised", 32'h1, 32'(irq));
      wr(A_INT_CLEAR, 32'h2, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(A_INT_ENABLE, 32'h1, RESP_OKAY);
      for (int c = 0; c < 3; c++) begin
         bus_rx_crc_bad <= (c == 1);
         fork
            begin
               rxq({16'h0006, 2'h0, 6'h07, 4'h3, 4'h3}, 1'b0);
               rxq(32'h11223344, c == 2);
               if (c != 2) rxq(32'h5566FFFF, 1'b1);
            end
            rx_expect(c);
         join
      end
      chk("irq rx", 32'h1, 32'(irq));
      results();
   end
endmodule
